// [rtl/iex_core.sv]
// instruction execution core: executes one instruction word per start
// assumes an APB master, and program memory answering pm_data for pm_addr
// within one clock
`timescale 1ns/1ps
`default_nettype none
module iex_core
    import iex_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program memory for table reads
    output logic [11:0] pm_addr,
    input wire logic [14:0] pm_data,
    // power-down indication
    output logic powerdown
);
    iex_state_t state_q;
    logic [31:0] instr_q, prdata_q;
    logic [7:0] acc_q, wdt_q;
    logic [11:0] pc_q, pm_addr_q;
    logic [6:0] table_high_latch_q;
    logic [1:0] ps_q;
    logic pre1_q, pre2_q;
    logic c_q, ac_q, z_q, ov_q, pdf_q, to_q, irqen_q;
    logic [3:0] cnt_q;
    logic [2:0] sp_q, sp_dn;
    logic [11:0] stack_q [STACK_DEPTH];
    logic [7:0] dmem_q [16];
    logic pready_q, pslverr_q, powerdown_q;
    iex_alu_if alu_bus ();
    iex_alu u_alu (.bus(alu_bus.alu));
    // instruction fields
    iex_op_t op;
    logic [2:0] bsel;
    logic [3:0] maddr;
    logic [7:0] imm, mval;
    logic [11:0] tgt;
    assign op = iex_op_t'(instr_q[OP_LSB +: 6]);
    assign bsel = instr_q[BIT_LSB +: 3];
    assign maddr = instr_q[MADDR_LSB +: 4];
    assign imm = instr_q[IMM_LSB +: 8];
    assign tgt = instr_q[TGT_LSB +: 12];
    assign mval = (maddr == PCL_INDEX) ? pc_q[7:0] : dmem_q[maddr];
    // top of stack slot; wraps so a pop at zero stays inside the array
    assign sp_dn = (sp_q == 3'h0) ? SP_TOP : sp_q - 3'h1;
    // decode results
    logic [7:0] acc_n, mem_n;
    logic mem_we, acc_we, skip, arith, logic_z, push, pop, jump;
    logic tbl, kick, pre1, pre2, halt, return_from_irq;
    logic [2:0] base, ncyc;
    logic [11:0] pc_n, tbl_addr;
    logic last;
    // per-instruction decode, all effects derived from current state
    always_comb begin
        acc_n = acc_q;
        mem_n = mval;
        {mem_we, acc_we, skip, arith, logic_z, push, pop, jump} = '0;
        {tbl, kick, pre1, pre2, halt, return_from_irq} = '0;
        base = CYC_ONE;
        tbl_addr = {pc_q[11:8], acc_q};
        alu_bus.a = acc_q;
        alu_bus.b = mval;
        alu_bus.cin = 1'b0;
        alu_bus.sel = AL_ADD;
        case (op)
            OP_JMP: begin base = CYC_TWO; jump = 1'b1; end
            OP_CALL: begin base = CYC_TWO; jump = 1'b1; push = 1'b1; end
            OP_RET: begin base = CYC_TWO; pop = 1'b1; end
            OP_RETA: begin
                base = CYC_TWO; pop = 1'b1; acc_we = 1'b1; acc_n = imm;
            end
            OP_RETURN_FROM_IRQ: begin base = CYC_TWO; pop = 1'b1; return_from_irq = 1'b1; end
            OP_SZ: skip = (mval == BYTE_ZERO);
            OP_SZA: begin
                skip = (mval == BYTE_ZERO); acc_we = 1'b1; acc_n = mval;
            end
            OP_SZB: skip = ~mval[bsel];
            OP_SNZB: skip = mval[bsel];
            OP_SIZ, OP_SDZ, OP_INC_SKIP_ZERO_TO_W, OP_DEC_SKIP_ZERO_TO_W: begin
                alu_bus.a = mval;
                alu_bus.b = (op == OP_SIZ || op == OP_INC_SKIP_ZERO_TO_W) ? BYTE_ONE : BYTE_ONES;
                skip = (alu_bus.res == BYTE_ZERO);
                if (op == OP_INC_SKIP_ZERO_TO_W || op == OP_DEC_SKIP_ZERO_TO_W) begin
                    acc_we = 1'b1; acc_n = alu_bus.res;
                end else begin
                    mem_we = 1'b1; mem_n = alu_bus.res;
                end
            end
            OP_TRDC, OP_TRDL: begin
                base = CYC_TWO; tbl = 1'b1; mem_we = 1'b1;
                mem_n = pm_data[7:0];
                if (op == OP_TRDL) tbl_addr = {4'hF, acc_q};
            end
            OP_CLRM: begin mem_we = 1'b1; mem_n = BYTE_ZERO; end
            OP_CLRB: begin
                mem_we = 1'b1; mem_n = mval & ~(BYTE_ONE << bsel);
            end
            OP_SETM: begin mem_we = 1'b1; mem_n = BYTE_ONES; end
            OP_KICK: kick = 1'b1;
            OP_PRE1: pre1 = 1'b1;
            OP_PRE2: pre2 = 1'b1;
            OP_SWAP: begin mem_we = 1'b1; mem_n = {mval[3:0], mval[7:4]}; end
            OP_SWAPA: begin acc_we = 1'b1; acc_n = {mval[3:0], mval[7:4]}; end
            OP_HALT: halt = 1'b1;
            OP_ADC, OP_ADD_CARRY_TO_MEM, OP_ADD, OP_ADDI, OP_ADD_TO_MEM: begin
                alu_bus.cin = (op == OP_ADC || op == OP_ADD_CARRY_TO_MEM) ? c_q : 1'b0;
                if (op == OP_ADDI) alu_bus.b = imm;
                arith = 1'b1;
                if (op == OP_ADD_CARRY_TO_MEM || op == OP_ADD_TO_MEM) begin
                    mem_we = 1'b1; mem_n = alu_bus.res;
                end else begin
                    acc_we = 1'b1; acc_n = alu_bus.res;
                end
            end
            OP_AND, OP_ANDI, OP_AND_TO_MEM: begin
                alu_bus.sel = AL_AND;
                if (op == OP_ANDI) alu_bus.b = imm;
                logic_z = 1'b1;
                if (op == OP_AND_TO_MEM) begin
                    mem_we = 1'b1; mem_n = alu_bus.res;
                end else begin
                    acc_we = 1'b1; acc_n = alu_bus.res;
                end
            end
            default: ;
        endcase
        // skip and pc-low write each add one cycle
        ncyc = base + {2'b00, skip} + {2'b00, mem_we && maddr == PCL_INDEX};
        if (jump) begin
            pc_n = tgt;
        end else if (pop) begin
            pc_n = stack_q[sp_dn];
        end else begin
            pc_n = pc_q + 12'h001 + {11'h000, skip};
        end
        if (mem_we && maddr == PCL_INDEX) pc_n = {pc_q[11:8], mem_n};
    end
    assign last = (cnt_q == 4'(32'(ncyc) * CLKS_PER_CYC - 1));
    // apb decode: writes act at the access edge unless refused at setup
    logic acc_edge, wr, rd_setup, dmem_hit, ok_addr;
    assign acc_edge = psel && penable && pready_q;
    assign wr = acc_edge && pwrite && !pslverr_q;
    assign rd_setup = psel && !penable;
    assign dmem_hit = (paddr[7:6] == DMEM_REGION) && (paddr[1:0] == 2'b00);
    assign ok_addr = dmem_hit || paddr == ADDR_INSTR || paddr == ADDR_STATUS
        || paddr == ADDR_ACC || paddr == ADDR_PC || paddr == ADDR_TABLE_HIGH_LATCH
        || paddr == ADDR_WDT;
    logic start, sw_ok;
    assign sw_ok = (state_q != S_RUN);
    assign start = wr && sw_ok && paddr == ADDR_INSTR;
    // apb answer: ready one cycle after setup, data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pready_q, pslverr_q} <= 2'b00;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= rd_setup;
            pslverr_q <= rd_setup && (!ok_addr
                || (pwrite && !sw_ok && paddr != ADDR_STATUS));
            prdata_q <= 32'h0000_0000;
            if (rd_setup && !pwrite) begin
                if (dmem_hit) begin
                    prdata_q <= {24'h000000, (paddr[5:2] == PCL_INDEX)
                        ? pc_q[7:0] : dmem_q[paddr[5:2]]};
                end else begin
                    case (paddr)
                        ADDR_INSTR: prdata_q <= instr_q;
                        ADDR_STATUS: begin
                            prdata_q[ST_OV:ST_C] <= {ov_q, z_q, ac_q, c_q};
                            prdata_q[ST_HALT:ST_PDF] <= {state_q == S_HALT,
                                state_q == S_RUN, to_q, pdf_q};
                            prdata_q[ST_IRQEN] <= irqen_q;
                            prdata_q[ST_SP +: 3] <= sp_q;
                        end
                        ADDR_ACC: prdata_q[7:0] <= acc_q;
                        ADDR_PC: prdata_q[11:0] <= pc_q;
                        ADDR_TABLE_HIGH_LATCH: prdata_q[6:0] <= table_high_latch_q;
                        ADDR_WDT: prdata_q[7:0] <= wdt_q;
                        default: ;
                    endcase
                end
            end
        end
    end
    // sequencer: run counts four clocks per instruction cycle
    logic wdt_ovf, commit;
    assign commit = (state_q == S_RUN) && last;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            instr_q <= 32'h0000_0000;
            powerdown_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                S_IDLE, S_HALT: begin
                    cnt_q <= 4'h0;
                    if (start) begin
                        instr_q <= pwdata;
                        state_q <= S_RUN;
                        powerdown_q <= 1'b0;
                    end else if (state_q == S_HALT && wdt_ovf) begin
                        state_q <= S_IDLE;
                        powerdown_q <= 1'b0;
                    end
                end
                S_RUN: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (last) begin
                        state_q <= halt ? S_HALT : S_IDLE;
                        powerdown_q <= halt;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
    // table read address presented while the instruction runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_addr_q <= 12'h000;
            table_high_latch_q <= 7'h00;
        end else if (ce) begin
            if (state_q == S_RUN) pm_addr_q <= tbl_addr;
            if (commit && tbl) table_high_latch_q <= pm_data[14:8];
        end
    end
    // accumulator, program counter and stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 8'h00;
            pc_q <= 12'h000;
            sp_q <= 3'h0;
            irqen_q <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= 12'h000;
        end else if (ce) begin
            if (commit) begin
                if (acc_we) acc_q <= acc_n;
                pc_q <= pc_n;
                if (return_from_irq) irqen_q <= 1'b1;
                if (push) begin
                    stack_q[sp_q] <= pc_q + 12'h001;
                    sp_q <= (sp_q == SP_TOP) ? 3'h0 : sp_q + 3'h1;
                end else if (pop) begin
                    sp_q <= sp_dn;
                end
            end else if (wr && sw_ok && paddr == ADDR_ACC) begin
                acc_q <= pwdata[7:0];
            end else if (wr && sw_ok && paddr == ADDR_PC) begin
                pc_q <= pwdata[11:0];
            end
        end
    end
    // data memory: instruction result or software load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) dmem_q[i] <= 8'h00;
        end else if (ce) begin
            if (commit && mem_we) begin
                dmem_q[maddr] <= mem_n;
            end else if (wr && sw_ok && dmem_hit) begin
                dmem_q[paddr[5:2]] <= pwdata[7:0];
            end
        end
    end
    // arithmetic flags; only add and and forms and software status writes touch them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c_q, ac_q, z_q, ov_q} <= 4'h0;
        end else if (ce) begin
            if (commit && arith) begin
                {c_q, ac_q, ov_q, z_q} <= {alu_bus.c, alu_bus.ac,
                    alu_bus.ov, alu_bus.z};
            end else if (commit && logic_z) begin
                z_q <= alu_bus.z;
            end else if (wr && sw_ok && paddr == ADDR_STATUS) begin
                {ov_q, z_q, ac_q, c_q} <= pwdata[ST_OV:ST_C];
            end
        end
    end
    // watchdog: prescaler of one instruction cycle, counter, flags
    logic wdt_clr, pair_done;
    assign wdt_ovf = (wdt_q == BYTE_ONES) && (ps_q == 2'(CLKS_PER_CYC - 1));
    assign pair_done = commit && ((pre1 && pre2_q) || (pre2 && pre1_q));
    assign wdt_clr = commit && (kick || halt) || pair_done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_q <= 8'h00;
            ps_q <= 2'h0;
            {pre1_q, pre2_q, pdf_q, to_q} <= 4'h0;
        end else if (ce) begin
            if (wdt_clr) begin
                wdt_q <= BYTE_ZERO;
                ps_q <= 2'h0;
            end else begin
                ps_q <= ps_q + 2'h1;
                if (ps_q == 2'(CLKS_PER_CYC - 1)) wdt_q <= wdt_q + 8'h01;
            end
            if (pair_done || (commit && kick)) begin
                {pre1_q, pre2_q} <= 2'b00;
            end else if (commit && pre1) begin
                pre1_q <= 1'b1;
            end else if (commit && pre2) begin
                pre2_q <= 1'b1;
            end
            if (commit && halt) begin
                pdf_q <= 1'b1;
            end else if (commit && kick || pair_done) begin
                pdf_q <= 1'b0;
            end
            if (wdt_ovf) begin
                to_q <= 1'b1;
            end else if (commit && (kick || halt) || pair_done) begin
                to_q <= 1'b0;
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pm_addr = pm_addr_q;
    assign powerdown = powerdown_q;
endmodule : iex_core
`default_nettype wire

// [rtl/iex_pkg.sv]
// constants, encodings and register map of the instruction execution block
// assumes an APB master with 32-bit data and byte addresses on paddr
//
// Operation
// - jump, call and the three returns take two cycles, flags untouched.
// - conditional skips take one cycle, plus one cycle when skipping.
// - memory writers take one extra cycle when writing pc low byte.
// - increment/decrement skip to memory can take both extra cycles.
// - skip on zero byte; copy variant loads accumulator; bit tests 0..7.
// - accumulator inc/dec skips leave memory, skip on zero result.
// - table reads load byte and high latch from page; two cycles.
// - watchdog kick zeroes counter, clears both watchdog flags, one cycle.
// - preclear clears flags only when the pair really clears watchdog.
// - halt enters power-down in one cycle and updates both flags.
// - halt stops execution, keeps state, clears watchdog, sets powerdown.
// - nibble swap exchanges halves; accumulator variant writes accumulator.
// - clearing byte or bit writes zeros, no flag change.
// - add-with-carry sums accumulator, byte and carry; sets four flags.
// - plain add ignores carry-in; byte or immediate; updates four flags.
// - and with byte or immediate updates only zero flag.
// - call pushes next address, then jumps to target.
package iex_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h08;
    localparam logic [7:0] ADDR_PC = 8'h0C;
    localparam logic [7:0] ADDR_TABLE_HIGH_LATCH = 8'h10;
    localparam logic [7:0] ADDR_WDT = 8'h14;
    localparam logic [1:0] DMEM_REGION = 2'h1;
    localparam logic [3:0] PCL_INDEX = 4'h0;
    // instruction word fields
    localparam int OP_LSB = 0;
    localparam int BIT_LSB = 6;
    localparam int MADDR_LSB = 9;
    localparam int IMM_LSB = 13;
    localparam int TGT_LSB = 9;
    // status word fields
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_PDF = 4;
    localparam int ST_TO = 5;
    localparam int ST_BUSY = 6;
    localparam int ST_HALT = 7;
    localparam int ST_IRQEN = 8;
    localparam int ST_SP = 9;
    // timing: one instruction cycle is four system clocks
    localparam int CLKS_PER_CYC = 4;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam int STACK_DEPTH = 6;
    localparam logic [2:0] SP_TOP = 3'h5;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_JMP = 6'h01, OP_CALL = 6'h02, OP_RET = 6'h03,
        OP_RETA = 6'h04, OP_RETURN_FROM_IRQ = 6'h05, OP_SZ = 6'h06, OP_SZA = 6'h07,
        OP_SZB = 6'h08, OP_SNZB = 6'h09, OP_SIZ = 6'h0A, OP_SDZ = 6'h0B,
        OP_INC_SKIP_ZERO_TO_W = 6'h0C, OP_DEC_SKIP_ZERO_TO_W = 6'h0D, OP_TRDC = 6'h0E, OP_TRDL = 6'h0F,
        OP_CLRM = 6'h10, OP_SETM = 6'h11, OP_KICK = 6'h12, OP_PRE1 = 6'h13,
        OP_PRE2 = 6'h14, OP_SWAP = 6'h15, OP_SWAPA = 6'h16, OP_HALT = 6'h17,
        OP_ADC = 6'h18, OP_ADD_CARRY_TO_MEM = 6'h19, OP_ADD = 6'h1A, OP_ADDI = 6'h1B,
        OP_ADD_TO_MEM = 6'h1C, OP_AND = 6'h1D, OP_ANDI = 6'h1E, OP_AND_TO_MEM = 6'h1F,
        OP_CLRB = 6'h20
    } iex_op_t;

    // gray coded along idle -> run -> halt
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_RUN = 2'b01, S_HALT = 2'b11
    } iex_state_t;

    typedef enum logic {AL_ADD = 1'b0, AL_AND = 1'b1} iex_alu_sel_t;
endpackage : iex_pkg

// [rtl/iex_alu_if.sv]
// operand and result bundle between the core and its arithmetic unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface iex_alu_if;
    import iex_pkg::*;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    iex_alu_sel_t sel;
    logic [7:0] res;
    logic c;
    logic ac;
    logic ov;
    logic z;
    modport core (output a, b, cin, sel, input res, c, ac, ov, z);
    modport alu (input a, b, cin, sel, output res, c, ac, ov, z);
endinterface : iex_alu_if
`default_nettype wire

// [rtl/iex_alu.sv]
// combinational 8-bit adder / and unit with flag outputs
// assumes operands are stable for the cycle in which results are used
`timescale 1ns/1ps
`default_nettype none
module iex_alu
    import iex_pkg::*;
(
    // operand and result bundle
    iex_alu_if.alu bus
);
    logic [8:0] sum;
    logic [4:0] lo;

    // add with carry-in, half carry and signed overflow
    always_comb begin
        sum = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
        lo = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
        if (bus.sel == AL_AND) begin
            bus.res = bus.a & bus.b;
        end else begin
            bus.res = sum[7:0];
        end
        bus.c = sum[8];
        bus.ac = lo[4];
        bus.ov = (bus.a[7] == bus.b[7]) && (sum[7] != bus.a[7]);
        bus.z = (bus.res == BYTE_ZERO);
    end
endmodule : iex_alu
`default_nettype wire

// [tb/iex_pmem.sv]
// program memory model answering table reads of the core
// assumes pm_addr from the core; replies with no latency
`timescale 1ns/1ps
`default_nettype none
module iex_pmem (
    // word address in, word out
    input wire logic [11:0] pm_addr,
    output logic [14:0] pm_data
);
    // word mixes page and offset so a wrong page shows up
    assign pm_data = {pm_addr[11:8], pm_addr[2:0], ~pm_addr[7:0]};
endmodule : iex_pmem
`default_nettype wire

// [tb/iex_core_sva.sv]
// port checks of the execution core: apb timing and power-down
// assumes one pclk domain and presetn active low
`timescale 1ns/1ps
`default_nettype none
module iex_core_sva
    import iex_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk, presetn, ce,
    // apb
    input wire logic psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // program memory and power-down
    input wire logic [11:0] pm_addr,
    input wire logic [14:0] pm_data,
    input wire logic powerdown
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup phase, and an accepted halt word
    sequence setup_s;
        psel && !penable && ce;
    endsequence
    sequence halt_s;
        pready && !pslverr && pwrite && paddr == ADDR_INSTR &&
        pwdata[5:0] == OP_HALT;
    endsequence
    chk_ready_next: assert property (setup_s |=> pready)
        else $error("no pready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_unmapped_err: assert property (pready && paddr == 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    chk_read_ok: assert property (pready && !pwrite && paddr <= ADDR_WDT &&
        paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("register read refused");
    chk_halt_pd: assert property (halt_s |-> ##[1:6] powerdown)
        else $error("halt did not power down");
    chk_halt_flags: assert property (pready && !pwrite &&
        paddr == ADDR_STATUS && powerdown && $past(powerdown)
        |-> prdata[ST_PDF] && !prdata[ST_TO])
        else $error("halt flags wrong");
endmodule : iex_core_sva
bind iex_core iex_core_sva iex_core_sva_i (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pm_addr, .pm_data, .powerdown);
`default_nettype wire

// [tb/iex_core_tb.sv]
// self-checking bench for the execution core over apb
// assumes iex_core, iex_pmem and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module iex_core_tb;
    import iex_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic powerdown, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] pm_addr;
    logic [14:0] pm_data;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    // design and program memory
    iex_core iex_core_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pm_addr, .pm_data,
        .powerdown);
    iex_pmem iex_pmem_i (.pm_addr, .pm_data);
    // clock
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    // hang ceiling
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer held until pready is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(rd, e);
    endtask : rc
    function automatic logic [31:0] ins(iex_op_t op, logic [2:0] b,
        logic [3:0] m, logic [7:0] x);
        return {11'h0, x, m, b, op};
    endfunction : ins
    // run a word; busy must still be up at 4n-1, gone at 4n+3
    task automatic run(input logic [31:0] w, input int n);
        xfer(1'h1, ADDR_INSTR, w);
        chk(err, 1'h0);
        repeat (4 * n - 3) @(posedge pclk);
        xfer(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[ST_BUSY], 1'h1);
        @(posedge pclk);
        xfer(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[ST_BUSY], 1'h0);
    endtask : run
    task automatic wrap_up();
        $display("done: %0d checks, %0d mismatches", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        presetn = 1'h0;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        rc(ADDR_STATUS, 32'h0);
        rc(8'h20, 32'h0);
        chk(err, 1'h1);
        // arithmetic and logic flags
        xfer(1'h1, ADDR_ACC, 32'h7F);
        run(ins(OP_ADDI, 3'h0, 4'h0, 8'h01), 1);
        rc(ADDR_ACC, 32'h80);
        rc(ADDR_STATUS, 32'hA);
        xfer(1'h1, ADDR_STATUS, 32'h1);
        xfer(1'h1, ADDR_ACC, 32'hFF);
        xfer(1'h1, 8'h44, 32'h0);
        run(ins(OP_ADC, 3'h0, 4'h1, 8'h00), 1);
        rc(ADDR_STATUS, 32'h7);
        xfer(1'h1, ADDR_STATUS, 32'h9);
        xfer(1'h1, ADDR_ACC, 32'hF0);
        xfer(1'h1, 8'h48, 32'h0F);
        run(ins(OP_AND_TO_MEM, 3'h0, 4'h2, 8'h00), 1);
        rc(8'h48, 32'h0);
        rc(ADDR_STATUS, 32'hD);
        $display("test alu done");
        // skips, pc-low penalties, call and return
        xfer(1'h1, ADDR_PC, 32'h010);
        run(ins(OP_SZ, 3'h0, 4'h1, 8'h00), 2);
        run(ins(OP_SNZB, 3'h0, 4'h1, 8'h00), 1);
        rc(ADDR_PC, 32'h013);
        xfer(1'h1, 8'h4C, 32'hFF);
        run(ins(OP_INC_SKIP_ZERO_TO_W, 3'h0, 4'h3, 8'h00), 2);
        rc(ADDR_ACC, 32'h0);
        rc(8'h4C, 32'hFF);
        xfer(1'h1, ADDR_PC, 32'h120);
        run(ins(OP_SETM, 3'h0, 4'h0, 8'h00), 2);
        rc(ADDR_PC, 32'h1FF);
        run(ins(OP_SIZ, 3'h0, 4'h0, 8'h00), 3);
        rc(ADDR_PC, 32'h100);
        xfer(1'h1, ADDR_PC, 32'h010);
        run(ins(OP_CALL, 3'h0, 4'h3, 8'h12), 2);
        rc(ADDR_PC, 32'h123);
        run(ins(OP_RET, 3'h0, 4'h0, 8'h00), 2);
        rc(ADDR_PC, 32'h011);
        $display("test flow done");
        // table reads, swap, bit clear
        xfer(1'h1, ADDR_ACC, 32'h05);
        xfer(1'h1, ADDR_PC, 32'h2A0);
        run(ins(OP_TRDC, 3'h0, 4'h4, 8'h00), 2);
        rc(8'h50, 32'hFA);
        rc(ADDR_TABLE_HIGH_LATCH, 32'h15);
        run(ins(OP_TRDL, 3'h0, 4'h4, 8'h00), 2);
        rc(ADDR_TABLE_HIGH_LATCH, 32'h7D);
        xfer(1'h1, 8'h54, 32'h3C);
        run(ins(OP_SWAPA, 3'h0, 4'h5, 8'h00), 1);
        rc(ADDR_ACC, 32'hC3);
        rc(8'h54, 32'h3C);
        xfer(1'h1, 8'h58, 32'hFF);
        run(ins(OP_CLRB, 3'h3, 4'h6, 8'h00), 1);
        rc(8'h58, 32'hF7);
        $display("test data done");
        // halt and watchdog clears
        run(ins(OP_HALT, 3'h0, 4'h0, 8'h00), 1);
        chk(powerdown, 1'h1);
        chk({rd[ST_TO], rd[ST_PDF]}, 2'h1);
        run(ins(OP_PRE1, 3'h0, 4'h0, 8'h00), 1);
        chk(rd[ST_PDF], 1'h1);
        run(ins(OP_PRE2, 3'h0, 4'h0, 8'h00), 1);
        chk(rd[ST_PDF], 1'h0);
        run(ins(OP_HALT, 3'h0, 4'h0, 8'h00), 1);
        run(ins(OP_KICK, 3'h0, 4'h0, 8'h00), 1);
        chk({rd[ST_TO], rd[ST_PDF]}, 2'h0);
        $display("test watchdog done");
        wrap_up();
    end
endmodule : iex_core_tb
`default_nettype wire
